// file: file_ram.v
/*
 * File register memory: 128 bytes, one write port and one read port.
 * Assumes a single clock; read data is registered, one cycle after the address.
 */
`timescale 1ns/100ps
module file_ram #(
  parameter AW = 7,
  parameter DW = 8
) (
  // Clock
  input wire clk,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // Read port
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// file: rot_sleep_checker.sv
/* Port checker for the rotate and sleep execution block.
   Assumes it is bound to rot_sleep_exec. */
`timescale 1ns/100ps
module rot_sleep_checker (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Core state
  input wire osc_enable,
  input wire sleep_state
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  osc_stop_a: assert property (osc_enable == !sleep_state)
    else $error("oscillator enable disagrees with sleep");
  sleep_entry_a: assert property (pready && pwrite && paddr == 8'h00
    && pwdata[1:0] == 2'h3 && !sleep_state |-> ##[1:4] sleep_state) else $error("no sleep");
  wake_up_a: assert property (pready && pwrite && paddr == 8'h08 && !pwdata[3]
    |=> !sleep_state) else $error("no wake");
  asleep_status_a: assert property (pready && !pwrite && paddr == 8'h08 && sleep_state
    |-> prdata[3:1] == 3'b110) else $error("bad status in sleep");
  status_bits_a: assert property (pready && !pwrite && paddr == 8'h08
    |-> prdata[31:4] == 28'h0) else $error("status upper bits set");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  unmapped_err_a: assert property (pready && !pwrite && paddr > 8'h14
    |-> pslverr && prdata == 32'h0) else $error("unmapped read");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error without ready");
endmodule
bind rot_sleep_exec rot_sleep_checker rot_sleep_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_enable(osc_enable),
  .sleep_state(sleep_state));

// file: rot_sleep_exec.v
/*
 * Execution of rotate-left and rotate-right through carry and of sleep entry,
 * with an APB slave for instruction issue, accumulator, status, watchdog view
 * and file register access.
 * Assumes one clock pclk and an asynchronous active-low reset presetn; the
 * wake-up logic outside clears the sleep state by a status write.
 */
// Our own choices: the APB slave port and the register addresses.
// Summary of operation
// [RULE_01] Rotate left: old carry into bit 0, old bit 7 becomes carry.
// [RULE_02] Rotate right: old carry into bit 7, old bit 0 becomes carry.
// [RULE_03] Destination 0 writes accumulator only; destination 1 writes file register.
// [RULE_04] Rotate carries 7-bit file address 0..127 and one destination bit.
// [RULE_05] Rotate left is one word, one execute cycle, changes only carry.
// [RULE_06] Sleep clears watchdog counter and its prescaler to zero.
// [RULE_07] Sleep clears power-down bit, sets time-out bit; other flags unchanged.
// [RULE_08] After sleep, execution halts and the oscillator stops.
// [RULE_09] Rotate right is one word and one execute cycle as well.
`timescale 1ns/100ps
`include "rot_sleep_map.vh"
module rot_sleep_exec #(
  parameter AW = 7,
  parameter DW = 8,
  parameter PW = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Core state
  output wire osc_enable,
  output wire sleep_state
);

  localparam S_IDLE = 3'h1;
  localparam S_FETCH = 3'h2;
  localparam S_EXEC = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg ack_r;
  reg exec_done_r;
  reg [1:0] op_r;
  reg dest_r;
  reg [AW-1:0] iaddr_r;
  reg [DW-1:0] wreg_r;
  reg carry_r;
  reg pd_n_r;
  reg to_n_r;
  reg sleep_r;
  reg [DW-1:0] wdog_r;
  reg [PW-1:0] presc_r;
  reg [AW-1:0] faddr_r;
  wire [DW-1:0] ram_rdata;
  wire idle;
  wire acc_first;
  wire wr_fire;
  wire mapped;
  wire [DW:0] rot_res;
  wire exec_rot;
  wire ram_we;
  wire [AW-1:0] ram_waddr;
  wire [DW-1:0] ram_wdata;
  wire [AW-1:0] ram_raddr;

  // Rotate through carry: returns {new carry, result}
  function [DW:0] rotate;
    input [1:0] op;
    input [DW-1:0] val;
    input cin;
    begin
      if (op == `OP_RLC) begin
        rotate = {val[DW-1], val[DW-2:0], cin}; // RULE_01
      end else begin
        rotate = {val[0], cin, val[DW-1:1]}; // RULE_02
      end
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `OFS_INSTR) || (a == `OFS_WREG) || (a == `OFS_STATUS) ||
        (a == `OFS_WDOG) || (a == `OFS_FDATA) || (a == `OFS_FADDR);
    end
  endfunction

  assign idle = state_r[0];
  // No access in the cycle after execute: file RAM read data is refreshed then
  assign acc_first = psel & penable & ~ack_r & idle & ~exec_done_r;
  assign pready = psel & penable & ack_r;
  assign mapped = is_mapped(paddr);
  assign pslverr = pready & ~mapped;
  assign wr_fire = pready & pwrite & mapped;
  assign osc_enable = ~sleep_r; // RULE_08
  assign sleep_state = sleep_r;

  assign exec_rot = state_r[2] & (op_r == `OP_RLC || op_r == `OP_RRC);
  assign rot_res = rotate(op_r, ram_rdata, carry_r);

  // File register write: rotate result when destination is 1, else APB data
  assign ram_we = (exec_rot & dest_r) | (wr_fire & (paddr == `OFS_FDATA)); // RULE_03
  assign ram_waddr = exec_rot ? iaddr_r : faddr_r;
  assign ram_wdata = exec_rot ? rot_res[DW-1:0] : pwdata[DW-1:0];
  assign ram_raddr = state_r[1] ? iaddr_r : faddr_r;

  file_ram #(
    .AW(AW),
    .DW(DW)
  ) u_ram (
    .clk(pclk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (wr_fire && paddr == `OFS_INSTR && !sleep_r &&
            pwdata[`INSTR_OP_MSB:`INSTR_OP_LSB] != `OP_NONE) begin
          state_nxt = S_FETCH;
        end
      end
      S_FETCH: state_nxt = S_EXEC;
      S_EXEC: state_nxt = S_IDLE; // RULE_05 RULE_09
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      ack_r <= 1'b0;
      exec_done_r <= 1'b0;
      prdata <= 32'h00000000;
      op_r <= `OP_NONE;
      dest_r <= 1'b0;
      iaddr_r <= `FADDR_RST;
      faddr_r <= `FADDR_RST;
    end else begin
      state_r <= state_nxt;
      ack_r <= acc_first;
      exec_done_r <= state_r[2];
      if (state_r[0] && state_nxt[1]) begin
        op_r <= pwdata[`INSTR_OP_MSB:`INSTR_OP_LSB];
        dest_r <= pwdata[`INSTR_DEST_BIT]; // RULE_04
        iaddr_r <= pwdata[`INSTR_ADDR_MSB:`INSTR_ADDR_LSB]; // RULE_04
      end
      if (wr_fire && paddr == `OFS_FADDR) begin
        faddr_r <= pwdata[AW-1:0];
      end
      if (acc_first && !pwrite) begin
        case (paddr)
          `OFS_INSTR: prdata <= {{17{1'b0}}, iaddr_r, 5'h00, dest_r, op_r};
          `OFS_WREG: prdata <= {24'h000000, wreg_r};
          `OFS_STATUS: prdata <= {28'h0000000, sleep_r, to_n_r, pd_n_r, carry_r};
          `OFS_WDOG: prdata <= {16'h0000, presc_r, wdog_r};
          `OFS_FDATA: prdata <= {24'h000000, ram_rdata};
          `OFS_FADDR: prdata <= {{25{1'b0}}, faddr_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Accumulator, status and sleep
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_r <= `WREG_RST;
      carry_r <= 1'b0;
      pd_n_r <= 1'b1;
      to_n_r <= 1'b1;
      sleep_r <= 1'b0;
    end else begin
      if (wr_fire && paddr == `OFS_WREG) begin
        wreg_r <= pwdata[DW-1:0];
      end
      if (wr_fire && paddr == `OFS_STATUS) begin
        carry_r <= pwdata[`ST_CARRY];
        if (!pwdata[`ST_SLEEP]) begin
          sleep_r <= 1'b0;
        end
      end
      if (exec_rot) begin
        carry_r <= rot_res[DW]; // RULE_05
        if (!dest_r) begin
          wreg_r <= rot_res[DW-1:0]; // RULE_03
        end
      end
      if (state_r[2] && op_r == `OP_SLEEP) begin
        pd_n_r <= 1'b0; // RULE_07
        to_n_r <= 1'b1; // RULE_07
        sleep_r <= 1'b1; // RULE_08
      end
    end
  end

  // Watchdog counter and prescaler
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_r <= `WDOG_CLEAR;
      presc_r <= `PRESC_CLEAR;
    end else if (state_r[2] && op_r == `OP_SLEEP) begin
      wdog_r <= `WDOG_CLEAR; // RULE_06
      presc_r <= `PRESC_CLEAR; // RULE_06
    end else begin
      presc_r <= presc_r + {{(PW-1){1'b0}}, 1'b1};
      if (&presc_r) begin
        wdog_r <= wdog_r + {{(DW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// file: rot_sleep_map.vh
/*
 * Register offsets, field positions, opcodes and reset values for the
 * rotate/sleep execution block.
 * Assumes byte addressing on a 32-bit APB; each register is one word.
 */
`ifndef ROT_SLEEP_MAP_VH
`define ROT_SLEEP_MAP_VH

// Register byte offsets
`define OFS_INSTR 8'h00
`define OFS_WREG 8'h04
`define OFS_STATUS 8'h08
`define OFS_WDOG 8'h0C
`define OFS_FDATA 8'h10
`define OFS_FADDR 8'h14

// Instruction word fields
`define INSTR_OP_LSB 0
`define INSTR_OP_MSB 1
`define INSTR_DEST_BIT 2
`define INSTR_ADDR_LSB 8
`define INSTR_ADDR_MSB 14

// Opcodes
`define OP_NONE 2'h0
`define OP_RLC 2'h1
`define OP_RRC 2'h2
`define OP_SLEEP 2'h3

// Status fields
`define ST_CARRY 0
`define ST_PD_N 1
`define ST_TO_N 2
`define ST_SLEEP 3

// Reset and forced values
`define WREG_RST 8'h00
`define WDOG_CLEAR 8'h00
`define PRESC_CLEAR 8'h00
`define FADDR_RST 7'h00

`endif

// file: testbench.sv
/* Self-checking bench for rot_sleep_exec.
   Assumes the APB register map of the block. */
`timescale 1ns/100ps
module testbench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rd, a, v, w;
  wire [31:0] prdata;
  wire pready, pslverr, osc_enable, sleep_state;
  reg er;
  reg [8:0] e;
  integer seed = 32'h722C74EE, miscompares = 0, samples_checked = 0, k;
  rot_sleep_exec rot_sleep_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_enable(osc_enable), .sleep_state(sleep_state));
  initial forever #50 pclk = ~pclk;
  function [8:0] rot(input [1:0] op, input [7:0] x, input c);
    rot = op == 2'h1 ? {x, c} : {x[0], c, x[7:1]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input wr, input [7:0] ad, input [31:0] d);
    if (psel) @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000 miscompares = miscompares + 1;
    summarize;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h08, 0); chk(rd, 32'h6);
    for (k = 0; k < 14; k = k + 1) begin
      a = $random(seed); v = $random(seed); w = $random(seed);
      if (k < 2) a[6:0] = k ? 7'h7F : 7'h00;
      apb(1, 8'h14, a[6:0]); apb(1, 8'h10, v[7:0]); apb(1, 8'h04, w[7:0]);
      apb(1, 8'h08, a[7]);
      apb(1, 8'h00, {a[6:0], 5'h0, a[8], a[9] ? 2'h2 : 2'h1});
      e = rot(a[9] ? 2'h2 : 2'h1, v[7:0], a[7]);
      apb(0, 8'h10, 0); chk(rd, a[8] ? e[7:0] : v[7:0]);
      apb(0, 8'h04, 0); chk(rd, a[8] ? w[7:0] : e[7:0]);
      apb(0, 8'h08, 0); chk(rd, {28'h0, 3'b011, e[8]});
      chk(er, 0);
      apb(0, 8'h00, 0); chk(rd, {a[6:0], 5'h0, a[8], a[9] ? 2'h2 : 2'h1});
    end
    apb(1, 8'h04, 32'h5A); apb(1, 8'h00, 32'h0); apb(0, 8'h04, 0); chk(rd, 32'h5A);
    apb(1, 8'h08, 1); apb(1, 8'h00, 32'h3);
    apb(0, 8'h08, 0); chk(rd, 32'hD);
    chk({osc_enable, sleep_state}, 2'b01);
    apb(0, 8'h0C, 0); chk(rd[7:0], 8'h00); chk(rd[15:8] < 8'h10, 1);
    apb(1, 8'h00, 32'h1); apb(0, 8'h08, 0); chk(rd, 32'hD);
    apb(1, 8'h08, 0); @(posedge pclk); chk({osc_enable, sleep_state}, 2'b10);
    apb(0, 8'h40, 0); chk(er, 1); chk(rd, 0);
    summarize;
  end
endmodule
